// File: include/afe_cfg_pkg.sv
// Purpose: constants and types for the front-end configuration bank
// Assumes: 24-bit serial frame, 8 address bits then 16 data bits
// Notes:   all register reset values are zero
package afe_cfg_pkg;
	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_MODE     = 8'h00;
	localparam logic [7:0] ADDR_CM       = 8'h02;
	localparam logic [7:0] ADDR_GAIN_FMT = 8'h0d;
	localparam logic [7:0] ADDR_GAIN_B   = 8'h33;
	localparam logic [7:0] ADDR_GAIN_C   = 8'h34;
	localparam logic [7:0] ADDR_BW       = 8'hc0;
	localparam logic [7:0] ADDR_RNG_LO   = 8'hc2;
	localparam logic [7:0] ADDR_RNG_HI   = 8'hc3;
	// ----------------------------------------------------------------
	// frame timing
	// ----------------------------------------------------------------
	localparam logic [4:0] SDO_EN_EDGE = 5'd8;
	localparam logic [4:0] FRAME_EDGES = 5'd24;
	localparam int POWER_UP_MS  = 25;
	localparam int CLK_HZ       = 50_000_000;
	localparam int POWER_UP_CYC = POWER_UP_MS * (CLK_HZ / 1000);
	localparam int SYNC_DELAY   = 3;
	// ----------------------------------------------------------------
	// field codes
	// ----------------------------------------------------------------
	localparam int RANGE_W = 3;
	localparam int FS_W    = 14;
	localparam logic [15:0] REG_RESET = 16'h0000;
	typedef enum logic [2:0] {
		CM_DEFAULT = 3'h0,
		CM_1V      = 3'h1,
		CM_HALF    = 3'h2,
		CM_6V      = 3'h3,
		CM_12V     = 3'h4
	} cm_tol_t;
	typedef enum logic [3:0] {
		PH0 = 4'h1,
		PH1 = 4'h2,
		PH2 = 4'h4,
		PH3 = 4'h8
	} phase_t;
	typedef struct packed {
		logic        read_mode;
		logic        cm_control_enable;
		logic [1:0]  cm_group_enable;
		logic [3:0]  cm_group_range;
		logic        gain_cal_en_a;
		logic        gain_cal_en_b;
		logic        gain_cal_en_c;
		logic        gain_cal_en_d;
		logic        twos_complement;
		logic [7:0]  chan_filter_bw_sel;
		logic [23:0] chan_range_code;
	} regs_t;
endpackage

// File: design/afe_cfg_bank.sv
// Purpose: configuration bank, serial port, frame marker and data clock
// Assumes: sample clock and sync arrive asynchronously to i_clk
// Notes:   registers live on the serial clock, copied over by toggle
`timescale 1ns/100ps
`default_nettype none
module afe_cfg_bank (
	input  wire logic                        i_clk,
	input  wire logic                        i_rst,
	input  wire logic                        i_spi_sclk,
	input  wire logic                        i_spi_cs_n,
	input  wire logic                        i_spi_sdi,
	output logic                             o_spi_sdo,
	output logic                             o_spi_sdo_oe,
	input  wire logic                        i_sample_clock,
	input  wire logic                        i_sample_sync_in,
	input  wire logic                        i_ddr_mode,
	input  wire logic [17:0]                 i_raw_code,
	output afe_cfg_pkg::regs_t               o_cfg,
	output logic                             o_gain_cal_active,
	output logic [8*afe_cfg_pkg::FS_W-1:0]   o_chan_full_scale_mv,
	output logic [5:0]                       o_cm_group_tol,
	output logic [17:0]                      o_coded_result,
	output logic                             o_frame_marker_out,
	output logic [1:0]                       o_chan_select,
	output logic                             o_data_clock_out
);
	// ----------------------------------------------------------------
	// serial frame, serial clock domain
	// ----------------------------------------------------------------
	afe_cfg_pkg::regs_t regs, next_regs;
	logic [4:0]  bit_cnt, next_bit_cnt;
	logic [22:0] shift, next_shift;
	logic [15:0] rd_data, next_rd_data;
	logic        next_oe, next_sdo, wr_tgl, next_wr_tgl;
	logic [7:0]  wr_addr;
	logic [15:0] wr_data;
	logic        frame_rst;
	assign frame_rst = i_rst | i_spi_cs_n;
	assign wr_addr   = shift[22:15];
	assign wr_data   = {shift[14:0], i_spi_sdi};

	function automatic logic [15:0] read_mux(input logic [7:0] a,
		input afe_cfg_pkg::regs_t r);
		logic [15:0] d;
		d = 16'h0000;
		if (a == afe_cfg_pkg::ADDR_MODE) begin
			d[0] = r.read_mode;
		end else if (a == afe_cfg_pkg::ADDR_CM) begin
			d[6:0] = {r.cm_group_range, r.cm_group_enable,
				r.cm_control_enable};
		end else if (a == afe_cfg_pkg::ADDR_GAIN_FMT) begin
			d[1:0] = {r.twos_complement, r.gain_cal_en_a};
		end else if (a == afe_cfg_pkg::ADDR_GAIN_B) begin
			d[1:0] = {r.gain_cal_en_c, r.gain_cal_en_b};
		end else if (a == afe_cfg_pkg::ADDR_GAIN_C) begin
			d[0] = r.gain_cal_en_d;
		end else if (a == afe_cfg_pkg::ADDR_BW) begin
			d[7:0] = r.chan_filter_bw_sel;
		end else if (a == afe_cfg_pkg::ADDR_RNG_LO) begin
			d[11:0] = r.chan_range_code[11:0];
		end else if (a == afe_cfg_pkg::ADDR_RNG_HI) begin
			d[11:0] = r.chan_range_code[23:12];
		end
		return d;
	endfunction

	always_comb begin
		next_bit_cnt = bit_cnt;
		if (bit_cnt != afe_cfg_pkg::FRAME_EDGES) begin
			next_bit_cnt = bit_cnt + 5'd1;
		end
		next_shift   = {shift[21:0], i_spi_sdi};
		next_rd_data = rd_data;
		next_oe      = o_spi_sdo_oe;
		if (bit_cnt == afe_cfg_pkg::SDO_EN_EDGE - 5'd1) begin
			next_rd_data = read_mux({shift[6:0], i_spi_sdi}, regs);
			next_oe      = regs.read_mode;
		end
		if (bit_cnt == afe_cfg_pkg::FRAME_EDGES - 5'd1) begin
			next_oe = 1'b0;
		end
	end

	always_ff @(posedge i_spi_sclk or posedge frame_rst) begin
		if (frame_rst) begin
			bit_cnt      <= 5'd0;
			shift        <= 23'h000000;
			rd_data      <= 16'h0000;
			o_spi_sdo_oe <= 1'b0;
		end else begin
			bit_cnt      <= next_bit_cnt;
			shift        <= next_shift;
			rd_data      <= next_rd_data;
			o_spi_sdo_oe <= next_oe;
		end
	end

	// bit order: first bit out is data bit 15
	always_comb begin
		next_sdo = 1'b0;
		if (bit_cnt >= afe_cfg_pkg::SDO_EN_EDGE &&
			bit_cnt < afe_cfg_pkg::FRAME_EDGES) begin
			next_sdo = rd_data[4'(5'd23 - bit_cnt)];
		end
	end

	always_ff @(negedge i_spi_sclk or posedge frame_rst) begin
		if (frame_rst) begin
			o_spi_sdo <= 1'b0;
		end else begin
			o_spi_sdo <= next_sdo;
		end
	end

	// writes land on the 24th rise; read mode blocks all but mode reg
	always_comb begin
		next_regs   = regs;
		next_wr_tgl = wr_tgl;
		if (!i_spi_cs_n && bit_cnt == afe_cfg_pkg::FRAME_EDGES - 5'd1 &&
			(!regs.read_mode || wr_addr == afe_cfg_pkg::ADDR_MODE)) begin
			next_wr_tgl = ~wr_tgl;
			if (wr_addr == afe_cfg_pkg::ADDR_MODE) begin
				next_regs.read_mode = wr_data[0];
			end else if (wr_addr == afe_cfg_pkg::ADDR_CM) begin
				{next_regs.cm_group_range, next_regs.cm_group_enable,
					next_regs.cm_control_enable} = wr_data[6:0];
			end else if (wr_addr == afe_cfg_pkg::ADDR_GAIN_FMT) begin
				{next_regs.twos_complement,
					next_regs.gain_cal_en_a} = wr_data[1:0];
			end else if (wr_addr == afe_cfg_pkg::ADDR_GAIN_B) begin
				{next_regs.gain_cal_en_c,
					next_regs.gain_cal_en_b} = wr_data[1:0];
			end else if (wr_addr == afe_cfg_pkg::ADDR_GAIN_C) begin
				next_regs.gain_cal_en_d = wr_data[0];
			end else if (wr_addr == afe_cfg_pkg::ADDR_BW) begin
				next_regs.chan_filter_bw_sel = wr_data[7:0];
			end else if (wr_addr == afe_cfg_pkg::ADDR_RNG_LO) begin
				next_regs.chan_range_code[11:0] = wr_data[11:0];
			end else if (wr_addr == afe_cfg_pkg::ADDR_RNG_HI) begin
				next_regs.chan_range_code[23:12] = wr_data[11:0];
			end else begin
				next_wr_tgl = wr_tgl;
			end
		end
	end

	always_ff @(posedge i_spi_sclk or posedge i_rst) begin
		if (i_rst) begin
			regs   <= '0;
			wr_tgl <= 1'b0;
		end else begin
			regs   <= next_regs;
			wr_tgl <= next_wr_tgl;
		end
	end

	a_sdo_enable: assert property (@(posedge i_spi_sclk)
		disable iff (frame_rst) $rose(o_spi_sdo_oe)
		|-> bit_cnt == 5'd8) else $error("sdo enabled off edge 8");
	a_sdo_release: assert property (@(posedge i_spi_sclk)
		disable iff (frame_rst) bit_cnt == 5'd24
		|-> !o_spi_sdo_oe) else $error("sdo held past edge 24");

	// ----------------------------------------------------------------
	// config copy into i_clk; regs stay still for a whole frame
	// ----------------------------------------------------------------
	logic tgl_s1, tgl_s2, tgl_s3, copy_evt;
	afe_cfg_pkg::regs_t next_cfg;
	assign copy_evt = tgl_s2 ^ tgl_s3;

	always_comb begin
		next_cfg = o_cfg;
		if (copy_evt) begin
			next_cfg = regs;
		end
	end

	// ----------------------------------------------------------------
	// derived settings
	// ----------------------------------------------------------------
	function automatic logic [13:0] fs_mv(input logic [2:0] code,
		input logic wide);
		logic [13:0] v;
		v = 14'd0;
		case (code)
			3'd0: v = wide ? 14'd5120 : 14'd5000;
			3'd1: v = wide ? 14'd3584 : 14'd3500;
			3'd2: v = wide ? 14'd2560 : 14'd2500;
			3'd3: v = wide ? 14'd7168 : 14'd7000;
			3'd4: v = wide ? 14'd10240 : 14'd10000;
			3'd5: v = wide ? 14'd12288 : 14'd12000;
			default: v = 14'd0;
		endcase
		return v;
	endfunction

	function automatic logic [2:0] cm_tol(input logic ctl,
		input logic en, input logic [1:0] rng);
		logic [2:0] t;
		t = afe_cfg_pkg::CM_DEFAULT;
		if (ctl && !en) begin
			t = afe_cfg_pkg::CM_1V;
		end else if (ctl && rng == 2'd0) begin
			t = afe_cfg_pkg::CM_HALF;
		end else if (ctl && rng == 2'd1) begin
			t = afe_cfg_pkg::CM_6V;
		end else if (ctl) begin
			t = afe_cfg_pkg::CM_12V;
		end
		return t;
	endfunction

	logic        next_cal;
	logic [8*afe_cfg_pkg::FS_W-1:0] next_fs;
	logic [5:0]  next_tol;
	logic [17:0] next_coded;
	assign next_cal = next_cfg.gain_cal_en_a & next_cfg.gain_cal_en_b &
		next_cfg.gain_cal_en_c & next_cfg.gain_cal_en_d;
	// range code 3'd6 and 3'd7 are undefined and report zero span
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_chan
			assign next_fs[gi*14 +: 14] = fs_mv(
				next_cfg.chan_range_code[gi*3 +: 3], !next_cal);
		end
		for (gi = 0; gi < 2; gi++) begin : g_grp
			assign next_tol[gi*3 +: 3] = cm_tol(next_cfg.cm_control_enable,
				next_cfg.cm_group_enable[gi],
				next_cfg.cm_group_range[gi*2 +: 2]);
		end
	endgenerate
	// offset binary in; msb flip gives two's complement for every channel
	assign next_coded = {i_raw_code[17] ^ o_cfg.twos_complement,
		i_raw_code[16:0]};

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			tgl_s1               <= 1'b0;
			tgl_s2               <= 1'b0;
			tgl_s3               <= 1'b0;
			o_cfg                <= '0;
			o_gain_cal_active    <= 1'b0;
			o_chan_full_scale_mv <= '0;
			o_cm_group_tol       <= 6'h00;
			o_coded_result       <= 18'h00000;
		end else begin
			tgl_s1               <= wr_tgl;
			tgl_s2               <= tgl_s1;
			tgl_s3               <= tgl_s2;
			o_cfg                <= next_cfg;
			o_gain_cal_active    <= next_cal;
			o_chan_full_scale_mv <= next_fs;
			o_cm_group_tol       <= next_tol;
			o_coded_result       <= next_coded;
		end
	end

	a_cal_all_four: assert property (@(posedge i_clk) disable iff (i_rst)
		o_gain_cal_active == (o_cfg.gain_cal_en_a & o_cfg.gain_cal_en_b &
		o_cfg.gain_cal_en_c & o_cfg.gain_cal_en_d))
		else $error("calibration active mismatch");
	a_widened_range: assert property (@(posedge i_clk) disable iff (i_rst)
		!o_gain_cal_active && o_cfg.chan_range_code[2:0] == 3'd5
		|-> o_chan_full_scale_mv[13:0] == 14'd12288)
		else $error("uncalibrated span wrong");
	a_cm_default: assert property (@(posedge i_clk) disable iff (i_rst)
		!o_cfg.cm_control_enable |-> o_cm_group_tol == 6'h00)
		else $error("common mode not default");
	a_format_msb: assert property (@(posedge i_clk) disable iff (i_rst)
		o_cfg.twos_complement && $stable(o_cfg.twos_complement) |=>
		o_coded_result[17] != $past(i_raw_code[17]))
		else $error("format not applied");
	a_copy_delay: assert property (@(posedge i_clk) disable iff (i_rst)
		copy_evt |=> o_cfg == $past(regs))
		else $error("config copy missed");

	// ----------------------------------------------------------------
	// frame marker, channel sequence and data clock
	// ----------------------------------------------------------------
	logic smp_s1, smp_s2, smp_s3, syn_s1, syn_s2;
	logic fall_evt, rise_evt, next_marker, next_dclk, dly, next_dly;
	afe_cfg_pkg::phase_t phase, next_phase;
	assign fall_evt = smp_s3 & ~smp_s2;
	assign rise_evt = ~smp_s3 & smp_s2;

	// sync and clock share latency, so the marker delay stays exact
	always_comb begin
		next_phase  = phase;
		next_marker = o_frame_marker_out;
		if (fall_evt && syn_s2) begin
			next_phase  = afe_cfg_pkg::PH0;
			next_marker = 1'b0;
		end else if (fall_evt) begin
			case (phase)
				afe_cfg_pkg::PH0: next_phase = afe_cfg_pkg::PH1;
				afe_cfg_pkg::PH1: next_phase = afe_cfg_pkg::PH2;
				afe_cfg_pkg::PH2: next_phase = afe_cfg_pkg::PH3;
				default:          next_phase = afe_cfg_pkg::PH0;
			endcase
			next_marker = (phase == afe_cfg_pkg::PH2) ||
				(phase == afe_cfg_pkg::PH3 && o_frame_marker_out);
		end
	end

	// ddr shifts the clock one cycle past the data change
	always_comb begin
		next_dly  = fall_evt & i_ddr_mode;
		next_dclk = o_data_clock_out;
		if (fall_evt && !i_ddr_mode) begin
			next_dclk = 1'b1;
		end else if (rise_evt && !i_ddr_mode) begin
			next_dclk = 1'b0;
		end else if (dly) begin
			next_dclk = ~o_data_clock_out;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			smp_s1             <= 1'b0;
			smp_s2             <= 1'b0;
			smp_s3             <= 1'b0;
			syn_s1             <= 1'b0;
			syn_s2             <= 1'b0;
			phase              <= afe_cfg_pkg::PH0;
			o_frame_marker_out <= 1'b0;
			o_chan_select      <= 2'd0;
			o_data_clock_out   <= 1'b0;
			dly                <= 1'b0;
		end else begin
			smp_s1             <= i_sample_clock;
			smp_s2             <= smp_s1;
			smp_s3             <= smp_s2;
			syn_s1             <= i_sample_sync_in;
			syn_s2             <= syn_s1;
			phase              <= next_phase;
			o_frame_marker_out <= next_marker;
			o_chan_select      <= {next_phase[2] | next_phase[3],
				next_phase[1] | next_phase[3]};
			o_data_clock_out   <= next_dclk;
			dly                <= next_dly;
		end
	end

	a_marker_phase: assert property (@(posedge i_clk) disable iff (i_rst)
		$rose(o_frame_marker_out) |-> phase == afe_cfg_pkg::PH3 &&
		$past(phase) == afe_cfg_pkg::PH2)
		else $error("marker rose off third fall");
	a_sync_resets: assert property (@(posedge i_clk) disable iff (i_rst)
		fall_evt && syn_s2 |=> phase == afe_cfg_pkg::PH0 &&
		!o_frame_marker_out && o_chan_select == 2'd0)
		else $error("sync did not reset sequence");
endmodule
`default_nettype wire

// File: verification/spi_host_model.sv
// Purpose: host controller model on the configuration serial port
// Assumes: serial clock idles low and runs only inside a frame
// Notes:   frames are 24 bits, address then data, msb first
`timescale 1ns/100ps
`default_nettype none
module spi_host_model #(
	parameter int HALF_NS = 24,
	parameter int PU_NS   = 1000
) (
	output logic      o_sclk,
	output logic      o_cs_n,
	output logic      o_sdi,
	input  wire logic i_sdo,
	input  wire logic i_sdo_oe
);
	// ----------------------------------------------------------------
	// idle levels
	// ----------------------------------------------------------------
	initial begin
		o_sclk = 1'b0;
		o_cs_n = 1'b1;
		o_sdi  = 1'b0;
	end
	// power-up time shortened so the run stays short
	task automatic wait_power_up();
		#PU_NS;
	endtask
	// ----------------------------------------------------------------
	// one full frame; read bits are taken on the rising edge
	// ----------------------------------------------------------------
	task automatic xfer(input logic [7:0] a, input logic [15:0] d,
		output logic [15:0] q, output logic oe_mid, output logic oe_end);
		logic [23:0] w;
		w      = {a, d};
		q      = 16'h0000;
		oe_mid = 1'b0;
		oe_end = 1'b1;
		o_cs_n = 1'b0;
		for (int i = 23; i >= 0; i--) begin
			o_sdi = w[i];
			#HALF_NS o_sclk = 1'b1;
			if (i <= 15) q[i] = i_sdo;
			if (i == 15) oe_mid = i_sdo_oe;
			#2;
			if (i == 0) oe_end = i_sdo_oe;
			#(HALF_NS - 2) o_sclk = 1'b0;
		end
		#HALF_NS o_cs_n = 1'b1;
		// released line must not keep showing the last bit
		o_sdi = ~o_sdi;
		// chip select stays high long enough to end the frame
		#(10 * HALF_NS);
	endtask
endmodule
`default_nettype wire

// File: verification/tb.sv
// Purpose: self-checking bench for the configuration bank
// Assumes: host model drives the serial port, bench drives the rest
// Notes:   expected values come from the range and code tables below
`timescale 1ns/100ps
`default_nettype none
module tb;
	logic                        i_clk = 1'b0;
	logic                        i_rst = 1'b1;
	logic                        smp_clk = 1'b0;
	logic                        sync_in = 1'b0;
	logic                        ddr_mode = 1'b0;
	logic [17:0]                 raw_code = 18'h00000;
	wire logic                   sclk;
	wire logic                   cs_n;
	wire logic                   sdi;
	logic                        sdo;
	logic                        sdo_oe;
	afe_cfg_pkg::regs_t          cfg;
	logic                        cal_active;
	logic [8*afe_cfg_pkg::FS_W-1:0] full_scale;
	logic [5:0]                  cm_tol;
	logic [17:0]                 coded;
	logic                        marker;
	logic [1:0]                  chan_sel;
	logic                        dclk;
	int                          err_count = 0;
	int                          checks_done = 0;
	int                          cycles = 0;
	logic [15:0]                 q;
	logic                        oe_mid;
	logic                        oe_end;
	int                          codes[8] = '{5, 4, 3, 0, 1, 2, 5, 4};
	logic [15:0]                 cm_word[5] = '{16'h0000, 16'h0001,
		16'h0007, 16'h002f, 16'h0057};
	logic [5:0]                  cm_exp[5] = '{6'o00, 6'o11, 6'o22,
		6'o33, 6'o44};
	realtime                     t0;
	int                          n;
	logic                        prev_dclk;
	// ----------------------------------------------------------------
	// clocks, instances
	// ----------------------------------------------------------------
	always #10 i_clk = ~i_clk;
	always #80 smp_clk = ~smp_clk;
	spi_host_model #(.HALF_NS(24), .PU_NS(1000)) i_host (
		.o_sclk   (sclk),
		.o_cs_n   (cs_n),
		.o_sdi    (sdi),
		.i_sdo    (sdo),
		.i_sdo_oe (sdo_oe)
	);
	afe_cfg_bank i_dut (
		.i_clk                (i_clk),
		.i_rst                (i_rst),
		.i_spi_sclk           (sclk),
		.i_spi_cs_n           (cs_n),
		.i_spi_sdi            (sdi),
		.o_spi_sdo            (sdo),
		.o_spi_sdo_oe         (sdo_oe),
		.i_sample_clock       (smp_clk),
		.i_sample_sync_in     (sync_in),
		.i_ddr_mode           (ddr_mode),
		.i_raw_code           (raw_code),
		.o_cfg                (cfg),
		.o_gain_cal_active    (cal_active),
		.o_chan_full_scale_mv (full_scale),
		.o_cm_group_tol       (cm_tol),
		.o_coded_result       (coded),
		.o_frame_marker_out   (marker),
		.o_chan_select        (chan_sel),
		.o_data_clock_out     (dclk)
	);
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic final_report();
		$display("checks=%0d mismatches=%0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// write, then let the copy into the system domain land
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		i_host.xfer(a, d, q, oe_mid, oe_end);
		repeat (8) @(posedge i_clk);
	endtask
	function automatic logic [13:0] fs_mv(input int code, input logic cal);
		int base;
		case (code)
			5: base = 12000;
			4: base = 10000;
			3: base = 7000;
			0: base = 5000;
			1: base = 3500;
			default: base = 2500;
		endcase
		return cal ? 14'(base) : 14'(base * 1024 / 1000);
	endfunction
	always @(posedge i_clk) begin
		cycles++;
		if (cycles == 20000) begin
			err_count++;
			final_report();
		end
	end
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (8) @(posedge i_clk);
		i_rst <= 1'b0;
		i_host.wait_power_up();
		check(64'(cfg), 64'h0);
		check(cm_tol, 6'o00);
		wr(afe_cfg_pkg::ADDR_RNG_LO, 16'h00e5);
		wr(afe_cfg_pkg::ADDR_RNG_HI, 16'h0951);
		for (int c = 0; c < 8; c++)
			check(full_scale[c*14 +: 14], fs_mv(codes[c], 1'b0));
		wr(afe_cfg_pkg::ADDR_GAIN_FMT, 16'h0001);
		wr(afe_cfg_pkg::ADDR_GAIN_B, 16'h0003);
		check(cal_active, 1'b0);
		wr(afe_cfg_pkg::ADDR_GAIN_C, 16'h0001);
		check(cal_active, 1'b1);
		for (int c = 0; c < 8; c++)
			check(full_scale[c*14 +: 14], fs_mv(codes[c], 1'b1));
		wr(afe_cfg_pkg::ADDR_BW, 16'h00a5);
		check(cfg.chan_filter_bw_sel, 8'ha5);
		// word 0x0007 enables both groups at range 0, giving CM_HALF
		for (int k = 0; k < 5; k++) begin
			wr(afe_cfg_pkg::ADDR_CM, cm_word[k]);
			check(cm_tol, cm_exp[k]);
		end
		@(posedge i_clk) raw_code <= 18'h20005;
		wr(afe_cfg_pkg::ADDR_GAIN_FMT, 16'h0003);
		check(coded, 18'h00005);
		wr(afe_cfg_pkg::ADDR_GAIN_FMT, 16'h0001);
		check(coded, 18'h20005);
		// read mode: every frame reads, only the mode register writes
		wr(afe_cfg_pkg::ADDR_MODE, 16'h0001);
		i_host.xfer(afe_cfg_pkg::ADDR_RNG_LO, 16'h0000, q, oe_mid, oe_end);
		check(q, 16'h00e5);
		check(oe_mid, 1'b1);
		check(oe_end, 1'b0);
		i_host.xfer(afe_cfg_pkg::ADDR_BW, 16'hffff, q, oe_mid, oe_end);
		check(q, 16'h00a5);
		i_host.xfer(8'h55, 16'h0000, q, oe_mid, oe_end);
		check(q, 16'h0000);
		wr(afe_cfg_pkg::ADDR_MODE, 16'h0000);
		check(cfg.chan_filter_bw_sel, 8'ha5);
		// sync taken at the sample clock fall, marker 3 to 4 periods on
		@(posedge smp_clk) sync_in <= 1'b1;
		@(negedge smp_clk) t0 = $realtime;
		@(posedge smp_clk) sync_in <= 1'b0;
		n = 0;
		// outputs looked at mid-cycle, away from the launching edge
		while (marker !== 1'b0 && n < 100) begin
			@(negedge i_clk);
			n++;
		end
		while (marker !== 1'b1 && n < 100) begin
			@(negedge i_clk);
			n++;
		end
		check(($realtime - t0 >= 480.0) && ($realtime - t0 <= 640.0), 1);
		check(chan_sel, 2'd3);
		// data clock rises once per sample period in SDR, half in DDR
		for (int m = 0; m < 2; m++) begin
			@(posedge i_clk) ddr_mode <= 1'(m);
			repeat (32) @(posedge i_clk);
			n = 0;
			@(negedge i_clk);
			prev_dclk = dclk;
			repeat (64) begin
				@(negedge i_clk);
				if (dclk === 1'b1 && prev_dclk === 1'b0) n++;
				prev_dclk = dclk;
			end
			check(n, (m == 0) ? 8 : 4);
		end
		final_report();
	end
endmodule
`default_nettype wire
